// ### tke_regs.vh
/*
 * tke_regs.vh: register layouts, reset values, mode codes and timing
 * counts for the touch key event logic.
 * assumes: included by tke_event_logic.v only.
 */
`ifndef TKE_REGS_VH
`define TKE_REGS_VH

// register indices on the command port (index order is our own)
`define TKE_IDX_CONFIG 2'h0
`define TKE_IDX_SENSOR_STATE_REG 2'h1
`define TKE_IDX_CLOCK 2'h2
`define TKE_IDX_ENABLE 2'h3

// reset values
`define TKE_CONFIG_RST 8'h00
`define TKE_SENSOR_STATE_REG_RST 8'h00
`define TKE_CLOCK_RST 8'h0c
`define TKE_ENABLE_RST 8'hff

// configuration fields
`define TKE_CFG_ROLE_HI 7
`define TKE_CFG_ROLE_LO 6
`define TKE_CFG_LATCH 5
`define TKE_CFG_KEY_HI 4
`define TKE_CFG_KEY_LO 3
`define TKE_CFG_IRQ_PRESS 1
`define TKE_CFG_MASK_PWR 0

// clock setting fields
`define TKE_CLK_FWD 7
`define TKE_CLK_IN 6
`define TKE_CLK_DIV_HI 4
`define TKE_CLK_DIV_LO 3
`define TKE_CLK_TRIM_HI 2
`define TKE_CLK_TRIM_LO 0

// key-press mode codes
`define TKE_KEY_ALL 2'b00
`define TKE_KEY_TWO 2'b01
`define TKE_KEY_ONE 2'b10

// cascade role codes
`define TKE_ROLE_PRIMARY 2'b10
`define TKE_ROLE_SECONDARY 2'b01

// divider: 64,16,4,1 oscillator ticks per internal clock tick
`define TKE_DIV_64 7'h40
`define TKE_DIV_16 7'h10
`define TKE_DIV_4 7'h04
`define TKE_DIV_1 7'h01

// fast start-up length in sampling rounds of that channel
`define TKE_STARTUP_ROUNDS 4'h8

// bus interrupt pattern: last tick count of a phase, so each phase of the start-stop pattern lasts six cycles
`define TKE_BUS_PHASE 4'h5

`endif

// ### tke_event_logic.v
/*
 * tke_event_logic.v: digital event logic of an eight channel touch
 * sensor: key-press filtering, sensor state register, interrupt pin and
 * bus start-stop interrupt, channel enables, clock divider and channel
 * scan sequencing.
 * assumes: a slave bus front end decodes commands into the one-cycle
 * strobes below; the analog front end gives a settled touch level per
 * channel on sense_inputs when its channel is sampled; osc_tick is one
 * pulse per oscillator period from a trimmed oscillator; clk_in_tick is
 * one pulse per edge of the cascade clock input.
 */
`include "tke_regs.vh"

// Function
// - all-keys mode reflects every press, and every release in direct mode
// - single-key mode admits first activation only
// - single-key mode interrupts on each admitted set
// - two-key mode admits first two activations
// - two-key mode interrupts once two bits set
// - press-only clear: interrupt on set events and, in direct mode, sensor releases
// - press-only set: interrupt only on set bits
// - reading sensor state clears interrupt
// - interrupt-clear command clears interrupt
// - bus interrupt is start then stop only
// - bus-interrupt command enables, soft reset disables
// - interrupt pin keeps working in bus mode
// - sensor state eight bits, read-only, resets zero
// - clock bit7 enables clock output pin
// - clock bit6 selects clock input, stops oscillator
// - divider field divides by 64,16,4,1
// - trim field scales oscillator, default 100
// - eight channels sampled in turn
// - secondary role runs from clock input
// - enable register one bit per channel
// - disabled channels ignored, optionally not sampled
// - newly enabled channel runs fast start-up
// - direct mode clears bit on release
// - latch mode read clears released bits only
// - key mode codes 00 all, 01 two, 10 one
module tke_event_logic #(
   parameter NCH = 8
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire osc_tick,
   input wire clk_in_tick,
   input wire [NCH-1:0] sense_inputs,
   input wire reg_wr,
   input wire reg_rd,
   input wire [1:0] reg_idx,
   input wire [7:0] reg_wdata,
   input wire irq_clear_cmd,
   input wire bus_irq_cmd,
   input wire soft_reset_cmd,
   output reg [7:0] reg_rdata,
   output wire irq_n,
   output wire sda_o,
   output wire sda_oe_n,
   output wire scl_o,
   output wire scl_oe_n,
   output wire clk_out_en,
   output wire clk_in_en,
   output wire osc_power_down,
   output wire [2:0] osc_trim,
   output wire [NCH-1:0] sample_strobe,
   output wire [NCH-1:0] fast_start,
   output wire [NCH-1:0] channel_powered
);

   // registers
   reg [7:0] config_reg; // mode settings
   reg [7:0] clock_setting_reg; // clock control
   reg [NCH-1:0] channel_enable_reg; // enable_bits
   reg [NCH-1:0] sensor_state_reg; // per_input_state
   reg irq_pend_reg; // interrupt pending
   reg bus_irq_en_reg; // start-stop signalling enabled
   reg [6:0] div_cnt_reg; // prescaler count
   reg [2:0] scan_reg; // channel being sampled
   reg [NCH-1:0] enable_prev_reg; // enables last cycle
   reg [2:0] bus_phase_reg; // start-stop pattern phase
   reg [3:0] bus_tick_reg; // ticks within a phase

   // field decode
   wire [1:0] cascade_role = config_reg[`TKE_CFG_ROLE_HI:`TKE_CFG_ROLE_LO];
   wire latch_select = config_reg[`TKE_CFG_LATCH];
   wire [1:0] keypress_select = config_reg[`TKE_CFG_KEY_HI:`TKE_CFG_KEY_LO];
   wire irq_on_press_only = config_reg[`TKE_CFG_IRQ_PRESS];
   wire masked_power_down = config_reg[`TKE_CFG_MASK_PWR];
   wire clock_forward_enable = clock_setting_reg[`TKE_CLK_FWD];
   wire clock_input_select = clock_setting_reg[`TKE_CLK_IN];
   wire [1:0] divider_select =
      clock_setting_reg[`TKE_CLK_DIV_HI:`TKE_CLK_DIV_LO];

   // divisor lookup for the coarse clock field
   function [6:0] tke_divisor;
      input [1:0] code;
      begin
         case (code)
            2'b00: tke_divisor = `TKE_DIV_64;
            2'b01: tke_divisor = `TKE_DIV_16;
            2'b10: tke_divisor = `TKE_DIV_4;
            default: tke_divisor = `TKE_DIV_1;
         endcase
      end
   endfunction

   // count of set bits; used for admission and two-key interrupt
   function [3:0] tke_popcount;
      input [NCH-1:0] v;
      integer k;
      begin
         tke_popcount = 4'h0;
         for (k = 0; k < NCH; k = k + 1) begin
            tke_popcount = tke_popcount + {3'h0, v[k]};
         end
      end
   endfunction

   // clock source: cascade input in secondary role or when selected
   wire secondary = (cascade_role == `TKE_ROLE_SECONDARY);
   assign clk_in_en = clock_input_select | secondary;
   assign osc_power_down = clk_in_en;
   assign clk_out_en = clock_forward_enable |
      (cascade_role == `TKE_ROLE_PRIMARY);
   assign osc_trim = clock_setting_reg[`TKE_CLK_TRIM_HI:`TKE_CLK_TRIM_LO];
   // trim only scales the analog oscillator; the logic sees its ticks
   wire src_tick = clk_in_en ? clk_in_tick : osc_tick;
   wire [6:0] divisor = tke_divisor(divider_select);
   // the cascade clock is already the internal clock, so no division
   wire clk_tick = src_tick &
      (clk_in_en | (div_cnt_reg >= divisor - 7'h01));

   // prescaler: one internal tick per divisor source ticks
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         div_cnt_reg <= 7'h00;
      end else if (clk_tick) begin
         div_cnt_reg <= 7'h00;
      end else if (src_tick) begin
         div_cnt_reg <= div_cnt_reg + 7'h01;
      end
   end

   // channel sampled this tick; disabled channels skipped when powered
   // down. the pointer steps past a skipped channel too, so one round is eight ticks.
   wire scan_live = channel_enable_reg[scan_reg] | ~masked_power_down;
   wire [NCH-1:0] scan_onehot = {{(NCH-1){1'b0}}, 1'b1} << scan_reg;
   assign sample_strobe = (clk_tick & scan_live) ? scan_onehot :
      {NCH{1'b0}};
   assign channel_powered = channel_enable_reg | {NCH{~masked_power_down}};

   // round-robin scan pointer
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         scan_reg <= 3'h0;
      end else if (clk_tick) begin
         scan_reg <= scan_reg + 3'h1;
      end
   end

   // per-channel fast start after a channel becomes enabled
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : g_start
         reg [3:0] cnt_reg; // fast start rounds left on this channel
         assign fast_start[g] = (cnt_reg != 4'h0);
         always @(posedge sys_clk) begin
            if (sys_rst) begin
               cnt_reg <= 4'h0;
            end else if (channel_enable_reg[g] & ~enable_prev_reg[g]) begin
               cnt_reg <= `TKE_STARTUP_ROUNDS;
            end else if (sample_strobe[g] & fast_start[g]) begin
               cnt_reg <= cnt_reg - 4'h1;
            end
         end
      end
   endgenerate

   // a channel's touch is seen only when enabled and started up
   wire [NCH-1:0] operational = channel_enable_reg & ~fast_start;

   // key-press filter: admit new presses lowest channel first
   reg [NCH-1:0] state_next;
   reg [NCH-1:0] admitted;
   reg [NCH-1:0] released; // set bits cleared by a sensor release
   reg [3:0] count_set;
   reg [3:0] limit;
   integer i;
   always @* begin
      state_next = sensor_state_reg;
      admitted = {NCH{1'b0}};
      released = {NCH{1'b0}};
      count_set = tke_popcount(sensor_state_reg);
      case (keypress_select)
         `TKE_KEY_TWO: limit = 4'h2;
         `TKE_KEY_ONE: limit = 4'h1;
         default: limit = 4'h8;
      endcase
      for (i = 0; i < NCH; i = i + 1) begin
         if (sample_strobe[i] & operational[i]) begin
            if (sense_inputs[i] & ~sensor_state_reg[i]) begin
               if (count_set < limit) begin
                  state_next[i] = 1'b1;
                  admitted[i] = 1'b1;
                  count_set = count_set + 4'h1;
               end
            end else if (~sense_inputs[i] & ~latch_select) begin
               state_next[i] = 1'b0;
               released[i] = sensor_state_reg[i];
            end
         end
      end
      // latch mode: read clears released bits only
      if (reg_rd & (reg_idx == `TKE_IDX_SENSOR_STATE_REG) & latch_select) begin
         for (i = 0; i < NCH; i = i + 1) begin
            if (~admitted[i] & ~(sense_inputs[i] & operational[i])) begin
               state_next[i] = 1'b0;
            end
         end
      end
   end

   wire [NCH-1:0] bits_set = state_next & ~sensor_state_reg;
   // clears by a latch read raise nothing, or a read would re-arm it
   // event per mode; two-key waits for two bits, others any set
   wire set_event = (keypress_select == `TKE_KEY_TWO) ?
      ((|bits_set) & (tke_popcount(state_next) >= 4'h2)) :
      (|bits_set);
   wire irq_event = set_event |
      ((|released) & ~irq_on_press_only);
   wire irq_clear = irq_clear_cmd |
      (reg_rd & (reg_idx == `TKE_IDX_SENSOR_STATE_REG));

   // state, pending interrupt and registers; a new event beats a clear
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         sensor_state_reg <= `TKE_SENSOR_STATE_REG_RST;
         irq_pend_reg <= 1'b0;
         enable_prev_reg <= `TKE_ENABLE_RST;
      end else begin
         sensor_state_reg <= state_next;
         enable_prev_reg <= channel_enable_reg;
         if (irq_event) begin
            irq_pend_reg <= 1'b1;
         end else if (irq_clear) begin
            irq_pend_reg <= 1'b0;
         end
      end
   end
   assign irq_n = ~irq_pend_reg;

   // writable registers; sensor state ignores writes
   always @(posedge sys_clk) begin
      if (sys_rst | soft_reset_cmd) begin
         config_reg <= `TKE_CONFIG_RST;
         clock_setting_reg <= `TKE_CLOCK_RST;
         channel_enable_reg <= `TKE_ENABLE_RST;
      end else if (reg_wr) begin
         case (reg_idx)
            `TKE_IDX_CONFIG: config_reg <= reg_wdata;
            `TKE_IDX_CLOCK: clock_setting_reg <= reg_wdata;
            `TKE_IDX_ENABLE: channel_enable_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // read data registered one cycle after the read strobe
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_idx)
            `TKE_IDX_CONFIG: reg_rdata <= config_reg;
            `TKE_IDX_SENSOR_STATE_REG: reg_rdata <= sensor_state_reg;
            `TKE_IDX_CLOCK: reg_rdata <= clock_setting_reg;
            default: reg_rdata <= channel_enable_reg;
         endcase
      end
   end

   // bus interrupt enable: set by command, cleared only by reset or soft reset
   always @(posedge sys_clk) begin
      if (sys_rst | soft_reset_cmd) begin
         bus_irq_en_reg <= 1'b0;
      end else if (bus_irq_cmd) begin
         bus_irq_en_reg <= 1'b1;
      end
   end

   // start-stop pattern phases
   localparam BUS_IDLE = 3'h0; // both lines released
   localparam BUS_START = 3'h1; // data low under high clock: start
   localparam BUS_LOW = 3'h2; // clock pulled low as well
   localparam BUS_HIGH = 3'h3; // clock released, data still low
   localparam BUS_STOP = 3'h4; // data released under high clock: stop
   // no arbitration: the pattern is short and the bus idle is assumed
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         bus_phase_reg <= BUS_IDLE;
         bus_tick_reg <= 4'h0;
      end else begin
         case (bus_phase_reg)
            BUS_IDLE: begin
               bus_tick_reg <= 4'h0;
               if (bus_irq_en_reg & irq_event) begin
                  bus_phase_reg <= BUS_START;
               end
            end
            BUS_START, BUS_LOW, BUS_HIGH, BUS_STOP: begin
               if (bus_tick_reg == `TKE_BUS_PHASE) begin
                  bus_tick_reg <= 4'h0;
                  bus_phase_reg <= (bus_phase_reg == BUS_STOP) ? BUS_IDLE :
                     bus_phase_reg + 3'h1;
               end else begin
                  bus_tick_reg <= bus_tick_reg + 4'h1;
               end
            end
            default: bus_phase_reg <= BUS_IDLE;
         endcase
      end
   end

   // open drain: enable low means the line is pulled low
   assign sda_o = 1'b0;
   assign scl_o = 1'b0;
   assign sda_oe_n = ~((bus_phase_reg == BUS_START) |
      (bus_phase_reg == BUS_LOW) | (bus_phase_reg == BUS_HIGH));
   assign scl_oe_n = ~(bus_phase_reg == BUS_LOW);

endmodule // tke_event_logic

// ### tke_event_logic_assertions.sv
/* tke_event_logic_assertions.sv: port assertions of the event logic.
   assumes: bound to tke_event_logic, one clock, sync reset. */
module tke_event_logic_assertions #(
   parameter NCH = 8
) (
   input wire sys_clk,
   input wire sys_rst,
   input wire reg_rd,
   input wire reg_wr,
   input wire [1:0] reg_idx,
   input wire [7:0] reg_wdata,
   input wire irq_clear_cmd,
   input wire soft_reset_cmd,
   input wire irq_n,
   input wire sda_oe_n,
   input wire scl_oe_n,
   input wire clk_in_en,
   input wire osc_power_down,
   input wire [2:0] osc_trim,
   input wire [NCH-1:0] sample_strobe
);
   default clocking dc @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // no strobe means no event can win against a clear
   wire idle = ~|sample_strobe;
   wire rd_sensor_state_reg = reg_rd && reg_idx == 2'h1;
   wire wr_clk = reg_wr && reg_idx == 2'h2 && !soft_reset_cmd;
   // one phase of the pattern lasts six cycles
   sequence sda_only_s;
      (!sda_oe_n && scl_oe_n) [*6];
   endsequence
   sequence both_low_s;
      (!sda_oe_n && !scl_oe_n) [*6];
   endsequence
   bus_pattern_a: assert property ($fell(sda_oe_n) |->
      sda_only_s ##1 both_low_s ##1 sda_only_s ##1 sda_oe_n)
      else $error("bus pattern wrong");
   scl_inside_a: assert property (!scl_oe_n |-> !sda_oe_n)
      else $error("clock line driven outside pattern");
   read_clears_a: assert property (rd_sensor_state_reg && idle |=> irq_n)
      else $error("read left interrupt pending");
   cmd_clears_a: assert property (irq_clear_cmd && idle |=> irq_n)
      else $error("clear command ignored");
   irq_holds_a: assert property (!irq_n && !rd_sensor_state_reg &&
      !irq_clear_cmd && !soft_reset_cmd |=> !irq_n)
      else $error("interrupt dropped");
   irq_cause_a: assert property ($fell(irq_n) |-> !$past(idle))
      else $error("interrupt without sample");
   one_strobe_a: assert property ($onehot0(sample_strobe))
      else $error("several channels sampled");
   osc_off_a: assert property (osc_power_down == clk_in_en)
      else $error("oscillator power wrong");
   trim_write_a: assert property (wr_clk |=>
      {5'h00, osc_trim} == ($past(reg_wdata) & 8'h07))
      else $error("trim not taken");
endmodule // tke_event_logic_assertions

// ### tke_bus_host.sv
/* tke_bus_host.sv: controller side of the two-wire bus; counts the
   start-stop interrupt patterns sent by the device.
   assumes: pull-ups on both lines, device pulls low by its enables. */
module tke_bus_host (
   input wire logic sys_clk,
   input wire logic sda_oe_n,
   input wire logic scl_oe_n,
   output int irq_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   // released lines float high through the pull-ups
   wire sda = sda_oe_n;
   wire scl = scl_oe_n;
   logic sda_d = 1'b1;
   logic started = 1'b0;
   initial irq_seen = 0;
   // start: data falls, clock high; stop: data rises, clock high
   always @(posedge sys_clk) begin
      sda_d <= sda;
      if (scl && sda_d && !sda)
         started <= 1'b1;
      if (scl && !sda_d && sda && started) begin
         irq_seen <= irq_seen + 1;
         started <= 1'b0;
      end
   end
endmodule // tke_bus_host

// ### tke_event_logic_tb.sv
/* tke_event_logic_tb.sv: self-checking bench of the touch key logic.
   assumes: checker and bus host model compiled first. */
module tke_event_logic_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0;
   logic sys_rst = 1;
   logic osc_tick = 1;
   logic reg_wr = 0;
   logic reg_rd = 0;
   logic rd_d = 0;
   logic irq_n, sda_oe_n, scl_oe_n, clk_out_en, clk_in_en;
   logic cin = 0; // cascade clock input ticks
   logic [1:0] reg_idx = 0;
   logic [2:0] cmd = 0; // bit0 clear, bit1 bus irq, bit2 soft reset
   logic [7:0] wdata = 0, sense = 0, rdata, fs, e, pwr;
   logic [7:0] exp_q[$]; // expected read data, oldest first
   int irq_seen, k, miscompares = 0, samples_checked = 0;
   initial forever #50 sys_clk = ~sys_clk;
   tke_event_logic tke_event_logic_i (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .osc_tick(osc_tick), .clk_in_tick(cin),
      .sense_inputs(sense), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_idx(reg_idx), .reg_wdata(wdata), .irq_clear_cmd(cmd[0]),
      .bus_irq_cmd(cmd[1]), .soft_reset_cmd(cmd[2]),
      .reg_rdata(rdata), .irq_n(irq_n), .sda_o(), .sda_oe_n(sda_oe_n),
      .scl_o(), .scl_oe_n(scl_oe_n), .clk_out_en(clk_out_en),
      .clk_in_en(clk_in_en), .osc_power_down(), .osc_trim(),
      .sample_strobe(), .fast_start(fs), .channel_powered(pwr));
   tke_bus_host tke_bus_host_i (.sys_clk(sys_clk),
      .sda_oe_n(sda_oe_n), .scl_oe_n(scl_oe_n), .irq_seen(irq_seen));
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      samples_checked++;
      if (seen !== want) begin
         miscompares++;
         $display("[ERR] %0t saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [1:0] i, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_idx <= i;
      wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // the read note goes in the queue; the monitor compares it
   task automatic rd(input logic [1:0] i, input logic [7:0] want);
      @(posedge sys_clk);
      exp_q.push_back(want);
      reg_rd <= 1'b1;
      reg_idx <= i;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   endtask
   task automatic pulse(input logic [2:0] c);
      @(posedge sys_clk);
      cmd <= c;
      @(posedge sys_clk);
      cmd <= 3'h0;
   endtask
   task automatic touch(input logic [7:0] v, input int n);
      @(posedge sys_clk);
      sense <= v;
      repeat (n) @(posedge sys_clk);
   endtask
   // wait up to n cycles for the pin level, sampled off the edge
   task automatic irq_is(input logic lvl, input int n);
      @(negedge sys_clk);
      for (int i = 0; i < n && irq_n !== lvl; i++)
         @(negedge sys_clk);
      check({7'h00, irq_n}, {7'h00, lvl});
   endtask
   task automatic started_up;
      for (int i = 0; i < 3000 && fs !== 8'h00; i++)
         @(negedge sys_clk);
   endtask
   // read data stands the cycle after the read was taken
   always @(posedge sys_clk) begin
      rd_d <= reg_rd;
      if (rd_d)
         check(rdata, exp_q.pop_front());
   end
   task automatic test_done;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      test_done;
   end
   initial begin
      void'($urandom(32'hd4bf7fed));
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h0c);
      rd(2'h3, 8'hff);
      wr(2'h1, 8'h5a);
      rd(2'h1, 8'h00);
      wr(2'h2, 8'h1c);
      rd(2'h2, 8'h1c);
      started_up;
      check(fs, 8'h00);
      // clock pins follow role and clock bits; secondary runs from cin
      wr(2'h2, 8'hdc);
      @(negedge sys_clk);
      check({6'h00, clk_out_en, clk_in_en}, 8'h03);
      wr(2'h2, 8'h1c);
      wr(2'h0, 8'h80);
      @(negedge sys_clk);
      check({6'h00, clk_out_en, clk_in_en}, 8'h02);
      wr(2'h0, 8'h40);
      touch(8'h01, 40);
      irq_is(1'b1, 0);
      @(posedge sys_clk);
      cin <= 1'b1;
      irq_is(1'b0, 40);
      check({6'h00, clk_out_en, clk_in_en}, 8'h01);
      rd(2'h1, 8'h01);
      touch(8'h00, 40);
      pulse(3'h1);
      wr(2'h0, 8'h00);
      // a masked channel neither sets its bit nor interrupts
      wr(2'h3, 8'hfe);
      wr(2'h0, 8'h01);
      @(negedge sys_clk);
      check(pwr, 8'hfe);
      touch(8'h01, 40);
      irq_is(1'b1, 0);
      rd(2'h1, 8'h00);
      touch(8'h00, 0);
      wr(2'h3, 8'hff);
      for (k = 0; k < 40 && fs[0] !== 1'b1; k++) @(negedge sys_clk);
      check(fs & 8'h01, 8'h01);
      check(pwr, 8'hff);
      started_up;
      // all-keys, direct: press then release both interrupt
      k = $urandom_range(7, 0);
      e = 8'h01 << k;
      touch(e, 0);
      irq_is(1'b0, 40);
      rd(2'h1, e);
      irq_is(1'b1, 2);
      touch(8'h00, 0);
      irq_is(1'b0, 40);
      rd(2'h1, 8'h00);
      // latching: release keeps the bit until a read
      wr(2'h0, 8'h20);
      e = 8'h01 << $urandom_range(7, 0);
      touch(e, 0);
      irq_is(1'b0, 40);
      touch(8'h00, 40);
      rd(2'h1, e);
      rd(2'h1, 8'h00);
      // press only: release does not interrupt
      wr(2'h0, 8'h02);
      touch(8'h10, 0);
      irq_is(1'b0, 40);
      pulse(3'h1);
      irq_is(1'b1, 2);
      touch(8'h00, 40);
      irq_is(1'b1, 0);
      // single key: second key never reaches the state
      wr(2'h0, 8'h10);
      touch(8'h04, 0);
      irq_is(1'b0, 40);
      touch(8'h24, 40);
      rd(2'h1, 8'h04);
      touch(8'h00, 40);
      pulse(3'h1);
      // two keys: interrupt only with two bits set
      wr(2'h0, 8'h08);
      touch(8'h02, 40);
      irq_is(1'b1, 0);
      touch(8'h0a, 0);
      irq_is(1'b0, 40);
      touch(8'h4a, 40);
      rd(2'h1, 8'h0a);
      touch(8'h00, 40);
      pulse(3'h1);
      // bus pattern on, pin still works; soft reset turns it off
      wr(2'h0, 8'h00);
      pulse(3'h2);
      touch(8'h80, 0);
      irq_is(1'b0, 40);
      repeat (30) @(posedge sys_clk);
      check(irq_seen[7:0], 8'h01);
      pulse(3'h4);
      pulse(3'h1);
      touch(8'h00, 0);
      irq_is(1'b0, 400);
      repeat (30) @(posedge sys_clk);
      check(irq_seen[7:0], 8'h01);
      repeat (4) @(posedge sys_clk);
      test_done;
   end
endmodule // tke_event_logic_tb
bind tke_event_logic tke_event_logic_assertions #(.NCH(NCH)) chk_i (
   .sys_clk, .sys_rst, .reg_rd, .reg_wr, .reg_idx, .reg_wdata,
   .irq_clear_cmd, .soft_reset_cmd, .irq_n, .sda_oe_n, .scl_oe_n,
   .clk_in_en, .osc_power_down, .osc_trim, .sample_strobe);
